/* rtl/cpu_regs_pkg.sv */
package cpu_regs_pkg;

  // register offsets on the apb bus, one aligned word each
  localparam logic [11:0] OFS_PC = 12'h000;
  localparam logic [11:0] OFS_ACC = 12'h004;
  localparam logic [11:0] OFS_TMP = 12'h008;
  localparam logic [11:0] OFS_IDX = 12'h00c;
  localparam logic [11:0] OFS_EXP = 12'h010;
  localparam logic [11:0] OFS_STK = 12'h014;
  localparam logic [11:0] OFS_PSW = 12'h018;
  localparam logic [11:0] OFS_CFG = 12'h01c;
  localparam logic [11:0] OFS_ALU = 12'h020;
  localparam logic [11:0] OFS_BANK = 12'h024;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BANK_PTR = 8'h00;
  localparam logic [1:0] RST_IL = 2'b11;
  localparam logic [1:0] RST_CFG = 2'b01;

  // address space layout inside the 64 kbyte map
  localparam logic [15:0] IO_LAST = 16'h007f;
  localparam logic [15:0] DATA_LAST = 16'h01ff;
  localparam logic [15:0] PROG_FIRST = 16'h8000;

  // general register banks
  localparam logic [15:0] BANK_BASE = 16'h0100;
  localparam int unsigned BANK_SHIFT = 3;
  localparam logic [7:0] BANKS_8 = 8'h08;
  localparam logic [7:0] BANKS_16 = 8'h10;
  localparam logic [7:0] BANKS_32 = 8'h20;

  // flag arithmetic constants
  localparam logic [3:0] NIB_MAX = 4'hf;
  localparam logic [1:0] IL_NONE = 2'b11;

  typedef enum logic [1:0] {
    REGION_IO = 2'b00,
    REGION_DATA = 2'b01,
    REGION_PROG = 2'b10,
    REGION_NONE = 2'b11
  } region_e;

  typedef enum logic [2:0] {
    ALU_NOP = 3'b000,
    ALU_ADD8 = 3'b001,
    ALU_SUB8 = 3'b010,
    ALU_ADD16 = 3'b011,
    ALU_SUB16 = 3'b100,
    ALU_SHL8 = 3'b101,
    ALU_SHR8 = 3'b110
  } alu_op_e;

  // condition code byte, msb first
  typedef struct packed {
    logic h;
    logic i;
    logic [1:0] il;
    logic n;
    logic z;
    logic v;
    logic c;
  } ccr_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage : cpu_regs_pkg

/* rtl/cpu_dedicated_register_set.sv */
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
// Operation
// RULE_01: one 64 kbyte space: i/o lowest, data above, program near top
// RULE_02: data area may hold register banks, stack and direct data
// RULE_03: 16-bit program counter gives the fetch address
// RULE_04: 16-bit accumulator; 8-bit ops touch only its low byte
// RULE_05: 16-bit temporary accumulator is second operand, low byte for 8-bit
// RULE_06: 16-bit index register, extra pointer and stack pointer
// RULE_07: status word: upper byte bank pointer, lower byte condition codes
// RULE_08: bank base address is 0x100 plus eight times bank pointer
// RULE_09: half-carry flags carry or borrow between bit 3 and bit 4
// RULE_10: interrupt enable 1 permits, 0 blocks, cleared by reset
// RULE_11: request served only if level beats field; 11 admits none
// RULE_12: negative flag copies result msb
// RULE_13: zero flag set for zero result, cleared otherwise
// RULE_14: overflow flag marks two's-complement overflow
// RULE_15: carry flag from bit 7; shifts load the bit shifted out
// RULE_16: general registers are 8-bit, eight per bank, in data memory
// RULE_17: usable banks are 8, 16 or 32, all starting at 0x0100
module cpu_dedicated_register_set (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb slave
  input wire cpu_regs_pkg::apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic pc_advance,
  input wire logic [2:0] gp_reg_sel,
  input wire logic [15:0] probe_addr,
  input wire logic irq_pending,
  input wire logic [1:0] irq_level,
  // decoded outputs
  output logic [15:0] fetch_addr,
  output logic [15:0] gp_reg_addr,
  output logic gp_reg_ok,
  output cpu_regs_pkg::region_e probe_region,
  output logic irq_take
);
  import cpu_regs_pkg::*;

  logic [15:0] pc_r;
  logic [15:0] acc_r;
  logic [15:0] tmp_r;
  logic [15:0] idx_r;
  logic [15:0] exp_r;
  logic [15:0] stk_r;
  logic [7:0] bank_ptr_r;
  ccr_s ccr_r;
  logic [1:0] bank_cfg_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [15:0] gp_addr_r;
  logic gp_ok_r;
  region_e region_r;
  logic irq_take_r;

  logic wr_en;
  logic rd_en;
  logic hit;
  logic [15:0] acc_nxt;
  ccr_s ccr_nxt;
  logic alu_go;
  alu_op_e alu_op;
  logic [15:0] bank_base;
  logic [7:0] bank_limit;
  region_e region_nxt;

  // slave answers in the access cycle, so every transfer has no wait
  assign pready = 1'b1;
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign fetch_addr = pc_r;
  assign gp_reg_addr = gp_addr_r;
  assign gp_reg_ok = gp_ok_r;
  assign probe_region = region_r;
  assign irq_take = irq_take_r;

  // address decode of the register map
  always_comb
  begin
    if (apb_req.paddr == OFS_PC) hit = 1'b1;
    else if (apb_req.paddr == OFS_ACC) hit = 1'b1;
    else if (apb_req.paddr == OFS_TMP) hit = 1'b1;
    else if (apb_req.paddr == OFS_IDX) hit = 1'b1;
    else if (apb_req.paddr == OFS_EXP) hit = 1'b1;
    else if (apb_req.paddr == OFS_STK) hit = 1'b1;
    else if (apb_req.paddr == OFS_PSW) hit = 1'b1;
    else if (apb_req.paddr == OFS_CFG) hit = 1'b1;
    else if (apb_req.paddr == OFS_ALU) hit = 1'b1;
    else if (apb_req.paddr == OFS_BANK) hit = 1'b1;
    else hit = 1'b0;
  end

  // a write to the alu word launches one operation on acc and tmp
  assign alu_go = wr_en & (apb_req.paddr == OFS_ALU);
  assign alu_op = alu_op_e'(apb_req.pwdata[2:0]);

  // flag and result computation
  always_comb
  begin
    logic [8:0] s8;
    logic [16:0] s16;
    logic [4:0] s4;
    s8 = 9'h000;
    s16 = 17'h00000;
    s4 = 5'h00;
    acc_nxt = acc_r;
    ccr_nxt = ccr_r;
    case (alu_op)
      ALU_ADD8, ALU_SUB8:
      begin
        // RULE_04: low byte only
        if (alu_op == ALU_ADD8)
        begin
          s8 = {1'b0, acc_r[7:0]} + {1'b0, tmp_r[7:0]};
          s4 = {1'b0, acc_r[3:0]} + {1'b0, tmp_r[3:0]};
          // RULE_14: add overflow
          ccr_nxt.v = (acc_r[7] == tmp_r[7]) && (s8[7] != acc_r[7]);
        end
        else
        begin
          s8 = {1'b0, acc_r[7:0]} - {1'b0, tmp_r[7:0]};
          s4 = {1'b0, acc_r[3:0]} - {1'b0, tmp_r[3:0]};
          // RULE_14: subtract overflow
          ccr_nxt.v = (acc_r[7] != tmp_r[7]) && (s8[7] != acc_r[7]);
        end
        acc_nxt = {acc_r[15:8], s8[7:0]};
        // RULE_09: nibble carry
        ccr_nxt.h = s4[4];
        // RULE_15: carry out of bit 7
        ccr_nxt.c = s8[8];
        // RULE_12: result msb
        ccr_nxt.n = s8[7];
        // RULE_13: zero result
        ccr_nxt.z = (s8[7:0] == 8'h00);
      end
      ALU_ADD16, ALU_SUB16:
      begin
        // RULE_05: full tmp word as operand
        if (alu_op == ALU_ADD16)
        begin
          s16 = {1'b0, acc_r} + {1'b0, tmp_r};
          s4 = {1'b0, acc_r[3:0]} + {1'b0, tmp_r[3:0]};
          ccr_nxt.v = (acc_r[15] == tmp_r[15]) && (s16[15] != acc_r[15]);
        end
        else
        begin
          s16 = {1'b0, acc_r} - {1'b0, tmp_r};
          s4 = {1'b0, acc_r[3:0]} - {1'b0, tmp_r[3:0]};
          ccr_nxt.v = (acc_r[15] != tmp_r[15]) && (s16[15] != acc_r[15]);
        end
        acc_nxt = s16[15:0];
        ccr_nxt.h = s4[4];
        ccr_nxt.c = s16[16];
        ccr_nxt.n = s16[15];
        ccr_nxt.z = (s16[15:0] == RST_WORD);
      end
      ALU_SHL8, ALU_SHR8:
      begin
        // RULE_15: shifted-out bit into carry
        if (alu_op == ALU_SHL8)
        begin
          acc_nxt = {acc_r[15:8], acc_r[6:0], 1'b0};
          ccr_nxt.c = acc_r[7];
        end
        else
        begin
          acc_nxt = {acc_r[15:8], 1'b0, acc_r[7:1]};
          ccr_nxt.c = acc_r[0];
        end
        ccr_nxt.n = acc_nxt[7];
        ccr_nxt.z = (acc_nxt[7:0] == 8'h00);
      end
      default:
      begin
        acc_nxt = acc_r;
        ccr_nxt = ccr_r;
      end
    endcase
  end

  // RULE_03: program counter, software load wins over the core step
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) pc_r <= RST_WORD;
    else if (wr_en && apb_req.paddr == OFS_PC) pc_r <= apb_req.pwdata[15:0];
    else if (pc_advance) pc_r <= pc_r + 16'h0001;
  end

  // RULE_04: accumulator
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) acc_r <= RST_WORD;
    else if (wr_en && apb_req.paddr == OFS_ACC)
      acc_r <= apb_req.pwdata[15:0];
    else if (alu_go) acc_r <= acc_nxt;
  end

  // RULE_05: temporary accumulator
  // RULE_06: address registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tmp_r <= RST_WORD;
      idx_r <= RST_WORD;
      exp_r <= RST_WORD;
      stk_r <= RST_WORD;
    end
    else if (wr_en)
    begin
      if (apb_req.paddr == OFS_TMP) tmp_r <= apb_req.pwdata[15:0];
      if (apb_req.paddr == OFS_IDX) idx_r <= apb_req.pwdata[15:0];
      if (apb_req.paddr == OFS_EXP) exp_r <= apb_req.pwdata[15:0];
      if (apb_req.paddr == OFS_STK) stk_r <= apb_req.pwdata[15:0];
    end
  end

  // RULE_07: status word split into bank pointer and flags
  // RULE_10: enable flag clears at reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      bank_ptr_r <= RST_BANK_PTR;
      ccr_r <= '{h: 1'b0, i: 1'b0, il: RST_IL, n: 1'b0, z: 1'b0,
                 v: 1'b0, c: 1'b0};
    end
    else if (wr_en && apb_req.paddr == OFS_PSW)
    begin
      bank_ptr_r <= apb_req.pwdata[15:8];
      ccr_r <= ccr_s'(apb_req.pwdata[7:0]);
    end
    else if (alu_go) ccr_r <= ccr_nxt;
  end

  // bank count follows the ram size fitted
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) bank_cfg_r <= RST_CFG;
    else if (wr_en && apb_req.paddr == OFS_CFG)
      bank_cfg_r <= apb_req.pwdata[1:0];
  end

  // RULE_08: bank base from pointer
  // RULE_17: all bank sets start at the same base
  // widen before the shift so no pointer bit falls off the top
  assign bank_base = BANK_BASE + ({8'h00, bank_ptr_r} << BANK_SHIFT);
  always_comb
  begin
    if (bank_cfg_r == 2'b00) bank_limit = BANKS_8;
    else if (bank_cfg_r == 2'b01) bank_limit = BANKS_16;
    else bank_limit = BANKS_32;
  end

  // RULE_16: eight byte registers per bank, checked against ram fitted
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      gp_addr_r <= BANK_BASE;
      gp_ok_r <= 1'b0;
    end
    else
    begin
      gp_addr_r <= bank_base + {13'h0000, gp_reg_sel};
      gp_ok_r <= bank_ptr_r < bank_limit;
    end
  end

  // RULE_01: region decode of the 64 kbyte map
  // RULE_02: banks, stack and direct data all fall in the data region
  always_comb
  begin
    if (probe_addr <= IO_LAST) region_nxt = REGION_IO;
    else if (probe_addr <= DATA_LAST) region_nxt = REGION_DATA;
    else if (probe_addr >= PROG_FIRST) region_nxt = REGION_PROG;
    else region_nxt = REGION_NONE;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst) region_r <= REGION_IO;
    else region_r <= region_nxt;
  end

  // RULE_10: enable gate
  // RULE_11: level gate, a request at level 3 is never taken
  always_ff @(posedge core_clk)
  begin
    if (sys_rst) irq_take_r <= 1'b0;
    else irq_take_r <= irq_pending & ccr_r.i & (irq_level != IL_NONE)
                       & (irq_level < ccr_r.il);
  end

  // read data and error are registered; unmapped offsets raise pslverr
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pslverr_r <= 1'b0;
      if (apb_req.psel && !apb_req.penable)
      begin
        pslverr_r <= ~hit;
        if (apb_req.paddr == OFS_PC) prdata_r <= {16'h0000, pc_r};
        else if (apb_req.paddr == OFS_ACC) prdata_r <= {16'h0000, acc_r};
        else if (apb_req.paddr == OFS_TMP) prdata_r <= {16'h0000, tmp_r};
        else if (apb_req.paddr == OFS_IDX) prdata_r <= {16'h0000, idx_r};
        else if (apb_req.paddr == OFS_EXP) prdata_r <= {16'h0000, exp_r};
        else if (apb_req.paddr == OFS_STK) prdata_r <= {16'h0000, stk_r};
        else if (apb_req.paddr == OFS_PSW)
          prdata_r <= {16'h0000, bank_ptr_r, ccr_r};
        else if (apb_req.paddr == OFS_CFG)
          prdata_r <= {30'h0000_0000, bank_cfg_r};
        else if (apb_req.paddr == OFS_BANK)
          prdata_r <= {15'h0000, gp_ok_r, bank_base};
        else prdata_r <= 32'h0000_0000;
      end
    end
  end

endmodule : cpu_dedicated_register_set

/* tb/cpu_regs_sva.sv */
`timescale 1ns/1ns
// port-level checks on the register set
module cpu_regs_sva
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb
  input wire cpu_regs_pkg::apb_req_s apb_req,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire logic pc_advance,
  input wire logic [2:0] gp_reg_sel,
  input wire logic [15:0] probe_addr,
  input wire logic irq_pending,
  input wire logic [1:0] irq_level,
  input wire logic [15:0] fetch_addr,
  input wire logic [15:0] gp_reg_addr,
  input wire cpu_regs_pkg::region_e probe_region,
  input wire logic irq_take
);
  import cpu_regs_pkg::*;
  logic pc_wr;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // a bus write to the counter wins over the step
  assign pc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
    && apb_req.paddr == OFS_PC;
  chk_pready_high: assert property (pready)
    else $error("pready low");
  chk_pc_step:
    assert property (pc_advance && !pc_wr |=>
      fetch_addr == $past(fetch_addr) + 16'h0001)
    else $error("pc did not step");
  chk_pc_hold:
    assert property (!pc_advance && !pc_wr |=> $stable(fetch_addr))
    else $error("pc moved");
  chk_irq_blocked:
    assert property (!irq_pending || irq_level == IL_NONE |=> !irq_take)
    else $error("irq taken while blocked");
  chk_irq_after_reset:
    assert property ($fell(sys_rst) |-> !irq_take ##1 !irq_take)
    else $error("irq taken after reset");
  chk_gp_index:
    assert property (1'b1 |=> gp_reg_addr[2:0] == $past(gp_reg_sel))
    else $error("register index wrong");
  chk_io_region:
    assert property (probe_addr <= IO_LAST |=> probe_region == REGION_IO)
    else $error("io region wrong");
  chk_prog_region:
    assert property (probe_addr >= PROG_FIRST |=>
      probe_region == REGION_PROG)
    else $error("program region wrong");
  chk_err_pulse:
    assert property (pslverr |->
      apb_req.psel && apb_req.penable ##1 !pslverr)
    else $error("error outside access");
  cover property (pc_wr);
  cover property ($rose(irq_take));
  cover property (pslverr);
  cover property (probe_region == REGION_PROG);
endmodule : cpu_regs_sva

bind cpu_dedicated_register_set cpu_regs_sva i_cpu_regs_sva (.core_clk,
  .sys_rst, .apb_req, .pready, .pslverr, .pc_advance, .gp_reg_sel,
  .probe_addr, .irq_pending, .irq_level, .fetch_addr, .gp_reg_addr,
  .probe_region, .irq_take);

/* tb/mem_map_model.sv */
`timescale 1ns/1ns
// layout of the memory behind the core, used as reference
module mem_map_model
(
  // probe
  input wire logic [15:0] addr,
  // class
  output cpu_regs_pkg::region_e region
);
  import cpu_regs_pkg::*;
  // io low, data above, program top
  always_comb
  begin
    if (addr <= IO_LAST)
      region = REGION_IO;
    else if (addr <= DATA_LAST)
      region = REGION_DATA;
    else if (addr >= PROG_FIRST)
      region = REGION_PROG;
    else
      region = REGION_NONE;
  end
endmodule : mem_map_model

/* tb/cpu_dedicated_register_set_tb_top.sv */
`timescale 1ns/1ns
// self-checking bench for the register set
module cpu_dedicated_register_set_tb_top;
  import cpu_regs_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  apb_req_s req = '0;
  logic pc_advance = 1'b0;
  logic [2:0] gp_reg_sel = 3'h0;
  logic [15:0] probe_addr = 16'h0000;
  logic irq_pending = 1'b0;
  logic [1:0] irq_level = 2'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, gp_reg_ok, irq_take, e;
  logic [15:0] fetch_addr, gp_reg_addr, a, t;
  region_e probe_region, ref_region;
  logic [23:0] x;
  logic [7:0] p, bp, cnt;
  logic [2:0] op;
  // region edges of the map, each side of every boundary
  logic [15:0] corner [8] = '{16'h0000, 16'h007f, 16'h0080, 16'h01ff,
    16'h0200, 16'h7fff, 16'h8000, 16'hffff};
  int mismatches = 0;
  int check_count = 0;

  // free-running core clock
  always #5 core_clk = ~core_clk;

  cpu_dedicated_register_set i_cpu_dedicated_register_set (.core_clk,
    .sys_rst, .apb_req(req), .prdata, .pready, .pslverr, .pc_advance,
    .gp_reg_sel, .probe_addr, .irq_pending, .irq_level, .fetch_addr,
    .gp_reg_addr, .gp_reg_ok, .probe_region, .irq_take);
  mem_map_model i_mem_map_model (.addr(probe_addr), .region(ref_region));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // one apb transfer, then an idle cycle so the next setup is a new step
  task automatic apb(input logic w, input logic [11:0] ad,
    input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, ad, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (n >= 20)
    begin
      chk(32'h0, 32'h1);
      tally_and_finish();
    end
    req <= '0;
    @(posedge core_clk);
  endtask : apb

  function automatic logic [23:0] alu_ref(input logic [2:0] o,
    input logic [15:0] u, input logic [15:0] s2, input logic [7:0] f);
    logic [16:0] s;
    logic [15:0] xa, ya, r;
    logic sb, w, h, n, z, v, c;
    sb = o == 3'd2 || o == 3'd4;
    w = o == 3'd3 || o == 3'd4;
    // 8-bit ops run in the top byte so one adder serves both widths
    xa = w ? u : {u[7:0], 8'h00};
    ya = w ? s2 : {s2[7:0], 8'h00};
    s = sb ? {1'b0, xa} - {1'b0, ya} : {1'b0, xa} + {1'b0, ya};
    h = sb ? u[3:0] < s2[3:0] : {1'b0, u[3:0]} + s2[3:0] > 5'h0f;
    v = xa[15] == (ya[15] ^ sb) && s[15] != xa[15];
    r = w ? s[15:0] : {u[15:8], s[15:8]};
    n = s[15];
    z = s[15:0] == 16'h0000;
    c = s[16];
    if (o == 3'd5 || o == 3'd6)
    begin
      h = f[7];
      v = f[1];
      c = o == 3'd5 ? u[7] : u[0];
      r = o == 3'd5 ? {u[15:8], u[6:0], 1'b0} : {u[15:8], 1'b0, u[7:1]};
      n = r[7];
      z = r[7:0] == 8'h00;
    end
    if (o == 3'd0 || o == 3'd7)
      return {u, f};
    return {r, h, f[6:4], n, z, v, c};
  endfunction : alu_ref

  // main sequence
  initial
  begin
    void'($urandom(6));
    tick(6);
    sys_rst <= 1'b0;
    apb(1'b0, OFS_PSW, 32'h0);
    chk(q, 32'h0000_0030);
    for (int o = 0; o < 6; o++)
    begin
      a = 16'($urandom);
      apb(1'b1, 12'(o * 4), {16'hffff, a});
      apb(1'b0, 12'(o * 4), 32'h0);
      chk(q, {16'h0000, a});
    end
    apb(1'b0, 12'h030, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, OFS_PC, 32'hfffe);
    pc_advance <= 1'b1;
    tick(3);
    pc_advance <= 1'b0;
    tick(1);
    chk(fetch_addr, 32'h1);
    // a bus load of the counter must win over a step in the same cycle
    pc_advance <= 1'b1;
    apb(1'b1, OFS_PC, 32'h1234);
    chk(fetch_addr, 32'h1234);
    pc_advance <= 1'b0;
    for (int k = 0; k < 24; k++)
    begin
      op = 3'(k);
      a = k < 8 ? 16'h7fff : 16'($urandom);
      t = k < 8 ? 16'h0001 : 16'($urandom);
      p = 8'h30 | (8'($urandom) & 8'h82);
      apb(1'b1, OFS_ACC, {16'h0000, a});
      apb(1'b1, OFS_TMP, {16'h0000, t});
      apb(1'b1, OFS_PSW, {24'h0, p});
      apb(1'b1, OFS_ALU, {29'h0, op});
      x = alu_ref(op, a, t, p);
      apb(1'b0, OFS_ACC, 32'h0);
      chk(q, {16'h0000, x[23:8]});
      apb(1'b0, OFS_PSW, 32'h0);
      chk(q, {24'h0, x[7:0]});
    end
    for (int c = 0; c < 12; c++)
    begin
      cnt = c / 3 > 1 ? 8'h20 : 8'h08 << (c / 3);
      bp = c % 3 == 0 ? cnt - 8'h01 : c % 3 == 1 ? cnt : 8'($urandom);
      apb(1'b1, OFS_CFG, 32'(c / 3));
      apb(1'b0, OFS_CFG, 32'h0);
      chk(q, 32'(c / 3));
      apb(1'b1, OFS_PSW, {16'h0, bp, 8'h30});
      gp_reg_sel <= 3'($urandom);
      tick(2);
      a = BANK_BASE + {5'h00, bp, 3'h0};
      chk(gp_reg_addr, {16'h0, a + gp_reg_sel});
      chk(gp_reg_ok, 32'(bp < cnt));
      apb(1'b0, OFS_BANK, 32'h0);
      chk(q, {15'h0, bp < cnt, a});
    end
    for (int k = 0; k < 16; k++)
    begin
      probe_addr <= k < 8 ? corner[k] : 16'($urandom);
      tick(2);
      chk(probe_region, ref_region);
    end
    for (int k = 0; k < 32; k++)
    begin
      apb(1'b1, OFS_PSW, {25'h0, k[4], k[3:2], 4'h0});
      irq_pending <= 2'($urandom) != 2'h0;
      irq_level <= k[1:0];
      tick(2);
      chk(irq_take, 32'(irq_pending && k[4] && k[1:0] < k[3:2]));
    end
    tally_and_finish();
  end
endmodule : cpu_dedicated_register_set_tb_top
